// ==== logic/cfps_ctrl.sv ====
// Clock fail monitor, sleep and idle sequencing and cpu slowdown control
`timescale 1ns/1ps

module cfps_ctrl #(
    parameter int FAIL_WINDOW    = cfps_pkg::FAIL_WINDOW,
    parameter int RESTART_CYCLES = cfps_pkg::RESTART_CYCLES
) (
    input  wire logic       clk,              // System clock, 40 MHz
    input  wire logic       rst,              // Synchronous reset, active high
    input  wire logic       clk_switch_monitor_config, // Config bit, 1 disables monitor
    input  wire logic       wdt_enable,       // Watchdog enabled
    input  wire logic [2:0] next_osc_select,  // Clock source selected by software
    input  wire logic       pll_in_use,       // PLL scales the system clock
    input  wire logic       osc_edge,         // Pulse per observed oscillator transition
    input  wire logic       low_power_rc_osc_tick,        // Pulse per low power RC period
    input  wire logic       power_save_instruction_exec,      // Power save instruction executes
    input  wire logic       power_save_instruction_operand,   // 0 sleep, 1 idle
    input  wire logic       irq,              // Enabled interrupt pending
    input  wire logic       wdt_timeout,      // Watchdog time-out
    input  wire logic       clock_divisor_register_wr,        // Clock divisor register write
    input  wire logic [15:0] clock_divisor_register_wdata,    // Write data
    output logic [15:0]     clock_divisor_register_rdata,     // Clock divisor register readback
    output logic [2:0]      clk_src_sel,      // Active system clock source
    output logic            fallback_pll,     // Fast RC fallback routed through PLL
    output logic            clk_fail,         // Oscillator failure latched
    output logic            fail_trap,        // One cycle clock failure trap
    output logic            low_power_rc_osc_run,         // Low power RC enable
    output logic            sys_osc_run,      // System oscillator enable
    output logic            cpu_clk_en,       // CPU clock enable
    output logic            periph_clk_en,    // System clocked peripherals enable
    output logic            wdt_clear,        // One cycle watchdog count clear
    output logic            cpu_resume,       // One cycle execution restart
    output logic            in_sleep,         // Device in Sleep
    output logic            in_idle           // Device in Idle
);

    cfps_pkg::cfps_state_t  state_q, state_d;
    cfps_pkg::cfps_clock_divisor_register_t div_q, div_d;
    cfps_pkg::cfps_ctrl_t   ctl_q, ctl_d;
    logic                   sleep_op_q, sleep_op_d;
    logic                   irq_hold_q, irq_hold_d;
    logic [2:0]             src_q, src_d;
    logic [2:0]             sel_q, sel_d;
    logic                   fail_q, fail_d;
    logic                   fpll_q, fpll_d;
    logic [$clog2(FAIL_WINDOW+1)-1:0]    win_q, win_d;
    logic [$clog2(RESTART_CYCLES+1)-1:0] rst_cnt_q, rst_cnt_d;
    logic [6:0]             doze_q, doze_d;
    logic                   mon_en;
    logic                   fail_hit;
    logic                   sleep_q, sleep_d;
    logic                   idle_q, idle_d;
    logic                   wake;
    logic [6:0]             doze_mask;

    // Clock divisor register; a software write in the same cycle wins over an interrupt clear
    always_comb begin
        div_d = div_q;
        if (div_q.return_on_interrupt && irq && div_q.cpu_slowdown_enable) begin
            div_d.cpu_slowdown_enable = 1'b0;
        end
        if (clock_divisor_register_wr) begin
            div_d.return_on_interrupt = clock_divisor_register_wdata[cfps_pkg::ROI_BIT];
            div_d.ratio               = clock_divisor_register_wdata[cfps_pkg::RATIO_HI:cfps_pkg::RATIO_LO];
            div_d.cpu_slowdown_enable = clock_divisor_register_wdata[cfps_pkg::CPU_SLOWDOWN_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= '{return_on_interrupt: 1'b0, ratio: cfps_pkg::RATIO_RESET,
                       cpu_slowdown_enable: 1'b0};
        end else begin
            div_q <= div_d;
        end
    end

    assign mon_en = (clk_switch_monitor_config != cfps_pkg::MON_CFG_OFF);

    // Fail-safe monitor, counts low power RC ticks since the last oscillator edge.
    // Counting stops once failed, so a dead oscillator gives one trap, not a stream.
    always_comb begin
        win_d    = win_q;
        fail_d   = fail_q;
        fpll_d   = fpll_q;
        fail_hit = 1'b0;
        if (!mon_en || state_q == cfps_pkg::CFPS_LOW && sleep_op_q || fail_q) begin
            win_d = '0;
        end else if (osc_edge) begin
            win_d = '0;
        end else if (low_power_rc_osc_tick) begin
            if (win_q == ($bits(win_q))'(FAIL_WINDOW - 1)) begin
                fail_hit = 1'b1;
                fail_d   = 1'b1;
                fpll_d   = pll_in_use;
                win_d    = '0;
            end else begin
                win_d = win_q + 1'b1;
            end
        end
    end

    // Failure stays latched until reset; software has no way to clear it
    always_ff @(posedge clk) begin
        if (rst) begin
            fail_q <= 1'b0;
            fpll_q <= 1'b0;
            win_q  <= '0;
        end else begin
            fail_q <= fail_d;
            fpll_q <= fpll_d;
            win_q  <= win_d;
        end
    end

    always_comb begin
        state_d    = state_q;
        ctl_d      = '0;
        sleep_op_d = sleep_op_q;
        irq_hold_d = irq_hold_q;
        src_d      = src_q;
        sel_d      = sel_q;
        rst_cnt_d  = rst_cnt_q;
        doze_d     = doze_q;

        wake      = irq || irq_hold_q || wdt_timeout;
        doze_mask = 7'((8'h01 << div_q.ratio) - 8'h01);

        if (fail_hit) begin
            ctl_d.fail_trap = 1'b1;
            sel_d           = cfps_pkg::OSC_FRC;
        end
        if (!fail_q && !fail_hit && state_q == cfps_pkg::CFPS_RUN) begin
            sel_d = next_osc_select;
        end

        case (state_q)
            cfps_pkg::CFPS_RUN: begin
                if (power_save_instruction_exec) begin
                    sleep_op_d = (power_save_instruction_operand == cfps_pkg::OPERAND_SLEEP);
                    irq_hold_d = irq;
                    src_d      = sel_q;
                    ctl_d.wdt_clear = wdt_enable || power_save_instruction_operand == cfps_pkg::OPERAND_IDLE;
                    state_d    = cfps_pkg::CFPS_ENTER;
                end
            end
            cfps_pkg::CFPS_ENTER: begin
                irq_hold_d = irq_hold_q || irq;
                state_d    = cfps_pkg::CFPS_LOW;
            end
            cfps_pkg::CFPS_LOW: begin
                if (wake) begin
                    irq_hold_d = 1'b0;
                    rst_cnt_d  = '0;
                    state_d    = cfps_pkg::CFPS_WAKE;
                    if (sleep_op_q) begin
                        sel_d = src_q;
                    end
                end
            end
            cfps_pkg::CFPS_WAKE: begin
                if (rst_cnt_q == ($bits(rst_cnt_q))'(RESTART_CYCLES - 1)) begin
                    ctl_d.cpu_resume = 1'b1;
                    state_d          = cfps_pkg::CFPS_RUN;
                end else begin
                    rst_cnt_d = rst_cnt_q + 1'b1;
                end
            end
            default: begin
                state_d = cfps_pkg::CFPS_RUN;
            end
        endcase

        // Clock enables for the next cycle
        sleep_d = (state_d == cfps_pkg::CFPS_LOW) && sleep_op_d;
        idle_d  = (state_d == cfps_pkg::CFPS_LOW) && !sleep_op_d;
        if (state_d == cfps_pkg::CFPS_LOW && sleep_op_d) begin
            ctl_d.sys_osc_run   = 1'b0;
            ctl_d.periph_clk_en = 1'b0;
            ctl_d.low_power_rc_osc_run      = wdt_enable;
        end else begin
            ctl_d.sys_osc_run   = 1'b1;
            ctl_d.periph_clk_en = 1'b1;
            ctl_d.low_power_rc_osc_run      = mon_en || wdt_enable;
        end

        // CPU clock: off while asleep or idle, divided only when slowed down
        if (state_d != cfps_pkg::CFPS_RUN || (state_q == cfps_pkg::CFPS_RUN && power_save_instruction_exec)) begin
            doze_d          = '0;
            ctl_d.cpu_clk_en = 1'b0;
        end else if (!div_d.cpu_slowdown_enable) begin
            doze_d          = '0;
            ctl_d.cpu_clk_en = 1'b1;
        end else begin
            // Enable on counter wrap keeps CPU edges aligned to peripheral edges
            ctl_d.cpu_clk_en = (doze_q == doze_mask);
            doze_d           = (doze_q == doze_mask) ? '0 : doze_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q    <= cfps_pkg::CFPS_RUN;
            ctl_q      <= '{low_power_rc_osc_run: 1'b1, sys_osc_run: 1'b1, cpu_clk_en: 1'b1,
                            periph_clk_en: 1'b1, default: 1'b0};
            sleep_op_q <= 1'b0;
            irq_hold_q <= 1'b0;
            src_q      <= cfps_pkg::OSC_FRC;
            sel_q      <= cfps_pkg::OSC_FRC;
            rst_cnt_q  <= '0;
            doze_q     <= '0;
            sleep_q    <= 1'b0;
            idle_q     <= 1'b0;
        end else begin
            state_q    <= state_d;
            ctl_q      <= ctl_d;
            sleep_op_q <= sleep_op_d;
            irq_hold_q <= irq_hold_d;
            src_q      <= src_d;
            sel_q      <= sel_d;
            rst_cnt_q  <= rst_cnt_d;
            doze_q     <= doze_d;
            sleep_q    <= sleep_d;
            idle_q     <= idle_d;
        end
    end

    // Outputs, all taken straight from flip-flops
    always_comb begin
        clock_divisor_register_rdata = cfps_pkg::CLOCK_DIVISOR_REGISTER_RESET;
        clock_divisor_register_rdata[cfps_pkg::ROI_BIT]                    = div_q.return_on_interrupt;
        clock_divisor_register_rdata[cfps_pkg::RATIO_HI:cfps_pkg::RATIO_LO] = div_q.ratio;
        clock_divisor_register_rdata[cfps_pkg::CPU_SLOWDOWN_ENABLE_BIT]                  = div_q.cpu_slowdown_enable;
        clk_src_sel   = sel_q;
        fallback_pll  = fpll_q;
        clk_fail      = fail_q;
        fail_trap     = ctl_q.fail_trap;
        low_power_rc_osc_run      = ctl_q.low_power_rc_osc_run;
        sys_osc_run   = ctl_q.sys_osc_run;
        cpu_clk_en    = ctl_q.cpu_clk_en;
        periph_clk_en = ctl_q.periph_clk_en;
        wdt_clear     = ctl_q.wdt_clear;
        cpu_resume    = ctl_q.cpu_resume;
        in_sleep      = sleep_q;
        in_idle       = idle_q;
    end

endmodule : cfps_ctrl

// ==== logic/cfps_pkg.sv ====
// Package with constants and types for the clock fail and power save control block
package cfps_pkg;

    // Clock divisor register field positions
    localparam int ROI_BIT        = 15;
    localparam int RATIO_HI       = 14;
    localparam int RATIO_LO       = 12;
    localparam int CPU_SLOWDOWN_ENABLE_BIT      = 11;
    localparam logic [2:0]  RATIO_RESET    = 3'h0;
    localparam logic [15:0] CLOCK_DIVISOR_REGISTER_RESET   = 16'h0000;

    // Oscillator source encodings
    localparam logic [2:0]  OSC_FRC        = 3'h0;

    // Power save instruction operands
    localparam logic        OPERAND_SLEEP  = 1'h0;
    localparam logic        OPERAND_IDLE   = 1'h1;

    // Fail window in low power RC ticks
    localparam int          FAIL_WINDOW    = 4;

    // Wake restart delay after sleep or idle, within the 2 to 4 cycle span
    localparam int          RESTART_CYCLES = 3;

    // Unprogrammed value of the clock switch and monitor configuration bit
    localparam logic        MON_CFG_OFF    = 1'h1;

    typedef enum logic [1:0] {
        CFPS_RUN   = 2'b00,
        CFPS_ENTER = 2'b01,
        CFPS_LOW   = 2'b11,
        CFPS_WAKE  = 2'b10
    } cfps_state_t;

    typedef struct packed {
        logic       return_on_interrupt;
        logic [2:0] ratio;
        logic       cpu_slowdown_enable;
    } cfps_clock_divisor_register_t;

    typedef struct packed {
        logic       low_power_rc_osc_run;
        logic       sys_osc_run;
        logic       cpu_clk_en;
        logic       periph_clk_en;
        logic       wdt_clear;
        logic       fail_trap;
        logic       cpu_resume;
    } cfps_ctrl_t;

endpackage : cfps_pkg

// ==== dv/cfps_osc_model.sv ====
// Model of the oscillator sources that feed the clock fail and power save block
`timescale 1ns/1ps

module cfps_osc_model (
    input  wire logic clk,         // System clock
    input  wire logic rst,         // Synchronous reset, active high
    input  wire logic sys_osc_run, // System oscillator enable from the block
    input  wire logic low_power_rc_osc_run,    // Low power RC enable from the block
    input  wire logic osc_dead,    // Breaks the system oscillator on purpose
    output logic      osc_edge,    // Transition seen on the system oscillator
    output logic      low_power_rc_osc_tick    // One pulse per low power RC period
);
    logic [2:0] div_q;

    always_ff @(posedge clk) begin
        div_q <= (rst || div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
    end
    // A stopped or broken oscillator shows no edges, so a loss is a real loss
    assign osc_edge  = sys_osc_run && !osc_dead && !rst;
    // No ticks while the block holds the low power RC off
    assign low_power_rc_osc_tick = low_power_rc_osc_run && div_q == 3'h4;
endmodule : cfps_osc_model

// ==== dv/cfps_ctrl_sva.sv ====
// Checker for the clock fail and power save control block
`timescale 1ns/1ps

module cfps_ctrl_sva (
    input wire logic       clk,                       // System clock
    input wire logic       rst,                       // Synchronous reset
    input wire logic       clk_switch_monitor_config, // Monitor config bit
    input wire logic       wdt_enable,                // Watchdog enabled
    input wire logic       pll_in_use,                // PLL in use
    input wire logic       power_save_instruction_exec,               // Power save instruction
    input wire logic       power_save_instruction_operand,            // Sleep or idle
    input wire logic       irq,                       // Enabled interrupt
    input wire logic       wdt_timeout,               // Watchdog time-out
    input wire logic [2:0] clk_src_sel,               // Active clock source
    input wire logic       fallback_pll,              // Fallback through PLL
    input wire logic       clk_fail,                  // Failure latched
    input wire logic       fail_trap,                 // Failure trap
    input wire logic       low_power_rc_osc_run,                  // Low power RC enable
    input wire logic       sys_osc_run,               // System oscillator enable
    input wire logic       cpu_clk_en,                // CPU clock enable
    input wire logic       periph_clk_en,             // Peripheral clock enable
    input wire logic       wdt_clear,                 // Watchdog clear
    input wire logic       cpu_resume,                // Execution restart
    input wire logic       in_sleep,                  // In Sleep
    input wire logic       in_idle                    // In Idle
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    property p_trap_once; fail_trap |-> !$past(clk_fail); endproperty
    a_trap_once: assert property (p_trap_once) else $error("trap repeated");
    property p_trap_src; fail_trap |-> clk_fail && clk_src_sel == cfps_pkg::OSC_FRC
        && fallback_pll == $past(pll_in_use); endproperty
    a_trap_src: assert property (p_trap_src) else $error("bad fallback");
    property p_sleep; in_sleep |-> !sys_osc_run && !periph_clk_en && !cpu_clk_en
        && !fail_trap && low_power_rc_osc_run == $past(wdt_enable); endproperty
    a_sleep: assert property (p_sleep) else $error("bad sleep clocks");
    property p_idle; in_idle |-> sys_osc_run && periph_clk_en && !cpu_clk_en; endproperty
    a_idle: assert property (p_idle) else $error("bad idle clocks");
    property p_low_power_rc_osc; !in_sleep && !$past(clk_switch_monitor_config) |-> low_power_rc_osc_run; endproperty
    a_low_power_rc_osc: assert property (p_low_power_rc_osc) else $error("low power RC off");
    property p_resume; $fell(in_idle || in_sleep) |-> !cpu_resume[*3] ##1 cpu_resume && cpu_clk_en;
    endproperty
    a_resume: assert property (p_resume) else $error("bad restart time");
    property p_wake; $fell(in_idle || in_sleep) |-> $past(irq || wdt_timeout) || $past(irq, 2)
        || $past(irq, 3) || $past(irq, 4); endproperty
    a_wake: assert property (p_wake) else $error("wake without cause");
    property p_clr; wdt_clear |-> $past(power_save_instruction_exec) && $past(power_save_instruction_operand || wdt_enable);
    endproperty
    a_clr: assert property (p_clr) else $error("stray watchdog clear");
endmodule : cfps_ctrl_sva

// ==== dv/cfps_ctrl_bench.sv ====
// Self-checking bench for the clock fail and power save control block
`timescale 1ns/1ps

module cfps_ctrl_bench;
    logic        clk = 1'b0, rst = 1'b1, clk_switch_monitor_config = 1'b0, wdt_enable = 1'b0;
    logic        pll_in_use = 1'b1, power_save_instruction_exec = 1'b0, power_save_instruction_operand = 1'b0, irq = 1'b0;
    logic        wdt_timeout = 1'b0, clock_divisor_register_wr = 1'b0, osc_dead = 1'b0;
    logic [2:0]  next_osc_select = 3'h5;
    logic [15:0] clock_divisor_register_wdata = 16'h0000;
    logic [15:0] clock_divisor_register_rdata;
    logic [2:0]  clk_src_sel;
    logic        fallback_pll, clk_fail, fail_trap, low_power_rc_osc_run, sys_osc_run, cpu_clk_en;
    logic        periph_clk_en, wdt_clear, cpu_resume, in_sleep, in_idle, osc_edge, low_power_rc_osc_tick;
    int          n_fail = 0, checks_done = 0, k;

    always #12.5 clk = ~clk;

    cfps_ctrl #(.FAIL_WINDOW(2)) cfps_ctrl_inst (
        .clk, .rst, .clk_switch_monitor_config, .wdt_enable, .next_osc_select, .pll_in_use,
        .osc_edge, .low_power_rc_osc_tick, .power_save_instruction_exec, .power_save_instruction_operand, .irq, .wdt_timeout, .clock_divisor_register_wr,
        .clock_divisor_register_wdata, .clock_divisor_register_rdata, .clk_src_sel, .fallback_pll, .clk_fail, .fail_trap,
        .low_power_rc_osc_run, .sys_osc_run, .cpu_clk_en, .periph_clk_en, .wdt_clear, .cpu_resume,
        .in_sleep, .in_idle);
    cfps_osc_model cfps_osc_model_inst (.clk, .rst, .sys_osc_run, .low_power_rc_osc_run, .osc_dead,
        .osc_edge, .low_power_rc_osc_tick);

    task automatic finish_test;
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // A wait that used its whole bound ends the run at once
    task automatic bnd(input string n);
        if (k >= 60) begin
            chk(n, 16'h0001, 16'h0000);
            finish_test();
        end
    endtask : bnd

    task automatic pulse(ref logic s);
        @(negedge clk) s = 1'b1;
        @(negedge clk) s = 1'b0;
    endtask : pulse

    task automatic wr_div(input logic [15:0] d);
        clock_divisor_register_wdata = d;
        pulse(clock_divisor_register_wr);
    endtask : wr_div

    task automatic t_doze;
        int n;
        for (int r = 0; r < 8; r++) begin
            wr_div({1'b0, r[2:0], 1'b1, 11'h7ff});
            chk("clock_divisor_register_rdata", {1'b0, r[2:0], 12'h800}, clock_divisor_register_rdata);
            n = 0;
            repeat (256) @(negedge clk) n += int'(cpu_clk_en === 1'b1);
            chk("cpu_clk_en count", 16'(256 >> r), 16'(n));
            chk("periph_clk_en", 16'h0001, periph_clk_en);
        end
        pulse(irq);
        chk("clock_divisor_register_rdata", 16'h7800, clock_divisor_register_rdata);
        wr_div(16'hb800);
        pulse(irq);
        chk("clock_divisor_register_rdata", 16'hb000, clock_divisor_register_rdata);
        repeat (8) @(negedge clk) chk("cpu_clk_en", 16'h0001, cpu_clk_en);
        wr_div(16'h0000);
    endtask : t_doze

    task automatic t_psave(input logic op, input logic wdt, input logic held);
        wdt_enable = wdt;
        @(negedge clk) {power_save_instruction_exec, power_save_instruction_operand, irq} = {1'b1, op, held};
        @(negedge clk) {power_save_instruction_exec, irq} = 2'b00;
        chk("wdt_clear", op | wdt, wdt_clear);
        for (k = 0; k < 60 && (in_idle | in_sleep) !== 1'b1; k++) @(negedge clk);
        bnd("low state");
        if (!held) begin
            repeat (30) @(negedge clk);
            chk("low state", 16'h0001, op ? in_idle : in_sleep);
            chk("sys_osc_run", op, sys_osc_run);
            next_osc_select = 3'h2;
            if (op) pulse(irq); else pulse(wdt_timeout);
        end
        for (k = 0; k < 60 && cpu_resume !== 1'b1; k++) @(negedge clk);
        bnd("cpu_resume");
        chk("clk_src_sel", 16'h0005, clk_src_sel);
        next_osc_select = 3'h5;
        chk("clk_fail", 16'h0000, clk_fail);
    endtask : t_psave

    task automatic t_fail;
        {wdt_enable, osc_dead, clk_switch_monitor_config} = {2'b11, cfps_pkg::MON_CFG_OFF};
        repeat (60) @(negedge clk);
        chk("clk_fail", 16'h0000, clk_fail);
        clk_switch_monitor_config = 1'b0;
        for (k = 0; k < 60 && fail_trap !== 1'b1; k++) @(negedge clk);
        bnd("fail_trap");
        chk("clk_src_sel", cfps_pkg::OSC_FRC, clk_src_sel);
        chk("fallback_pll", 16'h0001, fallback_pll);
        repeat (20) @(negedge clk) chk("fail_trap", 16'h0000, fail_trap);
    endtask : t_fail

    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        chk("clock_divisor_register_rdata", cfps_pkg::CLOCK_DIVISOR_REGISTER_RESET, clock_divisor_register_rdata);
        t_doze();
        t_psave(1'b1, 1'b0, 1'b0);
        t_psave(1'b0, 1'b1, 1'b0);
        t_psave(1'b0, 1'b0, 1'b0);
        t_psave(1'b1, 1'b1, 1'b1);
        t_fail();
        finish_test();
    end
endmodule : cfps_ctrl_bench

bind cfps_ctrl cfps_ctrl_sva cfps_ctrl_sva_inst (.*);
